// ==== hw/tac_pkg.sv ====
// =====================================================================
// shared constants and types of the temperature alarm control block
// =====================================================================
package tac_pkg;

  // =====================================================================
  // command byte layout
  // =====================================================================
  localparam int          CMD_RW_POS      = 7;       // 1 = read, 0 = write
  localparam int          CMD_ZERO_HI     = 6;       // must-be-zero field, top
  localparam int          CMD_ZERO_LO     = 3;       // must-be-zero field, bottom
  localparam logic [2:0]  REG_CONTROL     = 3'h1;    // control_status register
  localparam logic [2:0]  REG_UPPER       = 3'h2;    // upper_limit register
  localparam logic [2:0]  REG_LOWER       = 3'h3;    // lower_limit register

  // =====================================================================
  // control_status field positions
  // =====================================================================
  localparam int          CTL_SLEEP       = 15;      // sleep_request_bit
  localparam int          CTL_ONESHOT     = 14;      // single conversion request
  localparam int          CTL_ALM_CLEAR   = 13;      // alarm clear request
  localparam int          CTL_TOGGLE      = 12;      // conversion toggle
  localparam int          CTL_ALM_STATUS  = 11;      // alarm status
  localparam int          CTL_HIGH_FLAG   = 10;      // over upper limit seen
  localparam int          CTL_LOW_FLAG    = 9;       // under lower limit seen
  localparam int          CTL_DONE        = 8;       // conversion_done_flag
  localparam int          CTL_ALM_DIS     = 7;       // alarm output disable
  localparam int          CTL_POL         = 6;       // alarm_polarity
  localparam int          CTL_RES_HI      = 5;       // resolution_select_high
  localparam int          CTL_RES_LO      = 4;       // resolution_select_low
  localparam int          CTL_RSV_HI      = 2;       // reserved, read back
  localparam int          CTL_RSV_LO      = 1;       // reserved, read back

  // =====================================================================
  // limit layout and values after reset
  // =====================================================================
  localparam int          LIM_LSB         = 5;       // lowest kept limit bit
  localparam logic [15:0] CTL_RESET       = 16'h0000;
  localparam logic [15:0] UPPER_RESET     = 16'h4880;
  localparam logic [15:0] LOWER_RESET     = 16'h4600;

  // =====================================================================
  // frame bit counts
  // =====================================================================
  localparam logic [4:0]  CMD_LAST_BIT    = 5'h07;   // eighth command bit
  localparam logic [4:0]  DATA_LAST_BIT   = 5'h0F;   // sixteenth data bit

  // =====================================================================
  // types
  // =====================================================================
  typedef struct packed {
    logic cs_n;                                      // frame select, low active
    logic sck;                                       // link clock
    logic sio;                                       // serial data from host
  } tac_link_t;

  typedef enum logic [3:0] {
    PH_CMD  = 4'h1,                                  // shifting in command byte
    PH_RD   = 4'h2,                                  // shifting data out
    PH_WR   = 4'h4,                                  // shifting data in
    PH_DONE = 4'h8                                   // frame finished, wait cs
  } tac_phase_t;

  typedef enum logic [1:0] {
    CV_IDLE = 2'h1,                                  // no conversion running
    CV_BUSY = 2'h2                                   // conversion running
  } tac_conv_t;

endpackage

// ==== hw/tac_control.sv ====
// Summary of operation
// - set sleep bit and hold it to sleep
// - single request in sleep runs one conversion
// - single request ignored when continuous, reads zero
// - clear request drops alarm status, reads zero
// - alarm pin may lag clear one conversion
// - toggle bit inverts on read after conversion
// - status bit mirrors alarm; clear or low drops
// - clear while still hot re-asserts next conversion
// - high flag sets over limit, read clears once no longer over
// - low flag sets under limit, read clears once no longer under
// - done flag set on completion, read clears
// - disable bit turns alarm and status off
// - polarity bit picks asserted pin level
// - two bits select resolution thirteen to sixteen
// - bits three and zero zero; reserved read back
// - upper limit signed, raises alarm and flag
// - lower limit signed, drops alarm, sets flag
// - limit low five bits always read zero
// - command byte selects direction and register
// - sleep waits for running conversion to end
// - measurement is signed, sign in top bit
`timescale 1ns/1ps

module tac_control #(
  parameter int CONV_BASE_CYCLES = 100000            // 13-bit conversion length
) (
  input  wire logic               mclk_in,           // 10 MHz block clock
  input  wire logic               nrst_in,           // synchronous, low active
  input  wire tac_pkg::tac_link_t link_in,           // raw pins from host
  output logic                    link_sio_out,      // serial data to host
  output logic                    link_sio_oe_out,   // high while driving sio
  input  wire logic [15:0]        measurement_in,    // converter sample, same clock
  output logic [15:0]             result_out,        // last stored measurement
  output logic                    converting_out,    // conversion running
  output logic                    conv_done_out,     // one-cycle completion pulse
  output logic                    temperature_alarm_output_out  // alarm pin level
);
  import tac_pkg::*;

  // =====================================================================
  // state record
  // =====================================================================
  typedef struct packed {
    tac_link_t   s1;                                 // sync stage 1, only s2 reads it
    tac_link_t   s2;                                 // sync stage 2
    tac_link_t   s3;                                 // sync stage 3
    tac_link_t   filt;                               // accepted pin levels
    tac_phase_t  ph;                                 // frame phase
    logic [4:0]  cnt;                                // bit counter in phase
    logic [7:0]  cmd;                                // command shift register
    logic [15:0] sh;                                 // data shift register
    logic        sio;                                // data bit driven out
    logic        oe;                                 // sio drive enable
    logic        sleep;                              // sleep request
    logic        dis;                                // alarm disable
    logic        alarm_polarity;                                // alarm polarity
    logic [1:0]  res;                                // resolution select
    logic [1:0]  rsv;                                // reserved read-back bits
    logic        tog;                                // toggle value last read
    logic        pend;                               // conversion since last read
    logic        conversion_done_flag;                                // conversion done flag
    logic        hflag;                              // high limit history
    logic        lflag;                              // low limit history
    logic        above;                              // last result over upper
    logic        below;                              // last result under lower
    logic        alarm;                              // alarm latch, hysteresis
    logic [10:0] upper;                              // upper limit, bits 15:5
    logic [10:0] lower;                              // lower limit, bits 15:5
    tac_conv_t   cv;                                 // conversion state
    logic [23:0] ccnt;                               // cycles left in conversion
    logic [15:0] result;                             // stored measurement
    logic        done;                               // completion pulse
    logic        pin;                                // alarm pin level
  } tac_state_t;

  tac_state_t st;                                    // registered state
  tac_state_t next_st;                               // next state

  // =====================================================================
  // helpers
  // =====================================================================
  // conversion length doubles with each added resolution bit
  function automatic logic [23:0] conv_len(input logic [1:0] res);
    conv_len = 24'(CONV_BASE_CYCLES) << res;
  endfunction

  // readable image of a register; unmapped or malformed gives zero
  function automatic logic [15:0] reg_image(input logic [7:0] cmd,
                                            input logic [15:0] ctl,
                                            input logic [10:0] up,
                                            input logic [10:0] lo);
    reg_image = 16'h0000;
    if (cmd[CMD_ZERO_HI:CMD_ZERO_LO] == 4'h0) begin
      case (cmd[2:0])
        REG_CONTROL: reg_image = ctl;
        REG_UPPER:   reg_image = {up, 5'h00};
        REG_LOWER:   reg_image = {lo, 5'h00};
        default:     reg_image = 16'h0000;
      endcase
    end
  endfunction

  logic        rise;                                 // link clock rising
  logic        fall;                                 // link clock falling
  logic        rd_ctl;                               // control register read now
  logic        wr_go;                                // write word complete
  logic        oneshot_req;                          // single conversion request
  logic        clear_req;                            // alarm clear request
  logic        status;                               // alarm status as seen
  logic [7:0]  cmd_w;                                // full command byte
  logic [15:0] wr_w;                                 // full write word
  logic [15:0] ctl_w;                                // control register image
  logic signed [10:0] meas_top;                      // compared measurement bits

  // =====================================================================
  // next-state logic
  // =====================================================================
  always_comb begin
    next_st     = st;
    rd_ctl      = 1'b0;
    wr_go       = 1'b0;
    oneshot_req = 1'b0;
    clear_req   = 1'b0;
    next_st.done = 1'b0;
    // three-stage sampler; a change counts once stages 2 and 3 agree
    next_st.s1   = link_in;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.filt = tac_link_t'((st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3)));
    rise  = !st.filt.sck && next_st.filt.sck;
    fall  = st.filt.sck && !next_st.filt.sck;
    cmd_w = {st.cmd[6:0], next_st.filt.sio};
    wr_w  = {st.sh[14:0], next_st.filt.sio};
    status = st.alarm && !st.dis;
    // single and clear bits always show zero here
    ctl_w = {st.sleep, 1'b0, 1'b0, st.tog ^ st.pend, status, st.hflag,
             st.lflag, st.conversion_done_flag, st.dis, st.alarm_polarity, st.res, 1'b0, st.rsv, 1'b0};
    // ---- serial frame ----
    if (next_st.filt.cs_n) begin
      // deselect aborts any frame and releases the line
      next_st.ph  = PH_CMD;
      next_st.cnt = 5'h00;
      next_st.oe  = 1'b0;
    end else if (rise) begin
      next_st.cnt = st.cnt + 5'h01;
      case (st.ph)
        PH_CMD: begin
          next_st.cmd = cmd_w;
          if (st.cnt == CMD_LAST_BIT) begin
            next_st.cnt = 5'h00;
            if (cmd_w[CMD_RW_POS]) begin
              next_st.ph  = PH_RD;
              next_st.sh  = reg_image(cmd_w, ctl_w, st.upper, st.lower);
              next_st.sio = next_st.sh[15];
              next_st.oe  = 1'b1;
              rd_ctl = (cmd_w[CMD_ZERO_HI:CMD_ZERO_LO] == 4'h0) &&
                       (cmd_w[2:0] == REG_CONTROL);
            end else begin
              next_st.ph = PH_WR;
            end
          end
        end
        PH_RD: begin
          if (st.cnt == DATA_LAST_BIT) begin
            next_st.ph = PH_DONE;
            next_st.oe = 1'b0;
          end
        end
        PH_WR: begin
          next_st.sh = wr_w;
          if (st.cnt == DATA_LAST_BIT) begin
            next_st.ph = PH_DONE;
            wr_go = 1'b1;
          end
        end
        default: begin
          next_st.cnt = st.cnt;                      // ignore extra clocks
        end
      endcase
    end else if (fall && st.ph == PH_RD && st.cnt != 5'h00) begin
      // first bit was set up at load; shift only after host sampled it
      next_st.sh  = {st.sh[14:0], 1'b0};
      next_st.sio = st.sh[14];
    end
    // ---- register writes ----
    if (wr_go && st.cmd[CMD_ZERO_HI:CMD_ZERO_LO] == 4'h0) begin
      case (st.cmd[2:0])
        REG_CONTROL: begin
          next_st.sleep = wr_w[CTL_SLEEP];
          oneshot_req   = wr_w[CTL_ONESHOT];
          clear_req     = wr_w[CTL_ALM_CLEAR];
          next_st.dis   = wr_w[CTL_ALM_DIS];
          next_st.alarm_polarity   = wr_w[CTL_POL];
          next_st.res   = wr_w[CTL_RES_HI:CTL_RES_LO];
          next_st.rsv   = wr_w[CTL_RSV_HI:CTL_RSV_LO];
        end
        REG_UPPER: next_st.upper = wr_w[15:LIM_LSB];
        REG_LOWER: next_st.lower = wr_w[15:LIM_LSB];
        default:   next_st.cmd   = st.cmd;           // unmapped write dropped
      endcase
    end
    // ---- read side effects; completion below wins over them ----
    if (rd_ctl) begin
      next_st.tog  = st.tog ^ st.pend;
      next_st.pend = 1'b0;
      next_st.conversion_done_flag  = 1'b0;
      if (!st.above) next_st.hflag = 1'b0;
      if (!st.below) next_st.lflag = 1'b0;
    end
    // clear drops the latch now; a hot result re-arms it later
    if (clear_req) begin
      next_st.alarm = 1'b0;
    end
    // ---- conversion sequencer ----
    meas_top = $signed(measurement_in[15:LIM_LSB]);
    case (st.cv)
      CV_IDLE: begin
        if (!next_st.sleep) begin
          next_st.cv   = CV_BUSY;
          next_st.ccnt = conv_len(next_st.res) - 24'h000001;
        end else if (oneshot_req) begin
          next_st.cv   = CV_BUSY;
          next_st.ccnt = conv_len(next_st.res) - 24'h000001;
          next_st.conversion_done_flag  = 1'b0;                       // result stale until done
        end
      end
      CV_BUSY: begin
        // sleep is only looked at in idle, so a running one finishes
        if (st.ccnt == 24'h000000) begin
          next_st.cv     = CV_IDLE;
          next_st.done   = 1'b1;
          next_st.result = measurement_in;
          next_st.pend   = 1'b1;
          next_st.conversion_done_flag    = 1'b1;
          next_st.above  = meas_top > $signed(st.upper);
          next_st.below  = meas_top < $signed(st.lower);
          if (next_st.above) begin
            next_st.alarm = 1'b1;
            next_st.hflag = 1'b1;
          end else if (next_st.below) begin
            next_st.alarm = 1'b0;
            next_st.lflag = 1'b1;
          end
        end else begin
          next_st.ccnt = st.ccnt - 24'h000001;
        end
      end
      default: begin
        next_st.cv = CV_IDLE;
      end
    endcase
    // pin follows the status at once, well inside the allowed lag
    next_st.pin = next_st.alarm_polarity ? (next_st.alarm && !next_st.dis)
                              : !(next_st.alarm && !next_st.dis);
  end

  // =====================================================================
  // state register
  // =====================================================================
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      st             <= '0;
      st.s1.cs_n     <= 1'b1;                        // idle link is deselected
      st.s2.cs_n     <= 1'b1;
      st.s3.cs_n     <= 1'b1;
      st.filt.cs_n   <= 1'b1;
      st.ph          <= PH_CMD;
      st.cv          <= CV_IDLE;
      st.sleep       <= CTL_RESET[CTL_SLEEP];
      st.dis         <= CTL_RESET[CTL_ALM_DIS];
      st.alarm_polarity         <= CTL_RESET[CTL_POL];
      st.res         <= CTL_RESET[CTL_RES_HI:CTL_RES_LO];
      st.rsv         <= CTL_RESET[CTL_RSV_HI:CTL_RSV_LO];
      st.upper       <= UPPER_RESET[15:LIM_LSB];
      st.lower       <= LOWER_RESET[15:LIM_LSB];
      st.pin         <= 1'b1;                        // low polarity, not asserted
    end else begin
      st <= next_st;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  assign link_sio_out                 = st.sio;
  assign link_sio_oe_out              = st.oe;
  assign result_out                   = st.result;
  assign converting_out               = (st.cv == CV_BUSY);
  assign conv_done_out                = st.done;
  assign temperature_alarm_output_out = st.pin;

  // =====================================================================
  // assertions
  // =====================================================================
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  logic signed [10:0] done_meas;                     // measurement at completion
  assign done_meas = $signed(measurement_in[15:LIM_LSB]);

  property p_read_zero_bits;
    (st.ph == PH_CMD) && (next_st.ph == PH_RD) && rd_ctl
      |=> (st.sh[CTL_ONESHOT] == 1'b0) && (st.sh[CTL_ALM_CLEAR] == 1'b0) &&
          (st.sh[3] == 1'b0) && (st.sh[0] == 1'b0);
  endproperty
  a_read_zero_bits: assert property (p_read_zero_bits)
    else $error("control read shows nonzero command bits");

  property p_high_flag;
    (st.cv == CV_BUSY) && (st.ccnt == 24'h000000) && (done_meas > $signed(st.upper))
      |=> st.hflag && st.alarm && st.done;
  endproperty
  a_high_flag: assert property (p_high_flag)
    else $error("over-limit result did not set high flag and alarm");

  property p_low_flag;
    (st.cv == CV_BUSY) && (st.ccnt == 24'h000000) && (done_meas < $signed(st.lower))
      && !(done_meas > $signed(st.upper)) |=> st.lflag && !st.alarm;
  endproperty
  a_low_flag: assert property (p_low_flag)
    else $error("under-limit result did not set low flag or drop alarm");

  property p_clear_status;
    wr_go && clear_req && !((st.cv == CV_BUSY) && (st.ccnt == 24'h000000))
      |=> !st.alarm;
  endproperty
  a_clear_status: assert property (p_clear_status)
    else $error("alarm clear request did not drop status");

  property p_pin_level;
    st.pin == (st.alarm_polarity ? (st.alarm && !st.dis) : !(st.alarm && !st.dis));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("alarm pin level disagrees with status and polarity");

  property p_disable;
    st.dis && $stable(st.dis) |-> st.pin == !st.alarm_polarity;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disabled alarm pin not at inactive level");

  property p_done_sets_flag;
    st.done |-> st.conversion_done_flag && st.pend && (st.cv == CV_IDLE);
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag)
    else $error("completion did not set done flag");

  property p_sleep_finishes;
    st.sleep && (st.cv == CV_BUSY) && (st.ccnt != 24'h000000) |=> (st.cv == CV_BUSY);
  endproperty
  a_sleep_finishes: assert property (p_sleep_finishes)
    else $error("running conversion stopped before its end");

  property p_sleep_stays;
    // only the next cycle is promised: a single request may land right after
    st.sleep && (st.cv == CV_IDLE) && !oneshot_req && next_st.sleep
      |=> (st.cv == CV_IDLE);
  endproperty
  a_sleep_stays: assert property (p_sleep_stays)
    else $error("conversion started in sleep without request");

  property p_toggle_read;
    rd_ctl && st.pend |=> st.tog != $past(st.tog);
  endproperty
  a_toggle_read: assert property (p_toggle_read)
    else $error("toggle bit did not invert after conversion");

  property p_limit_low_zero;
    (next_st.ph == PH_RD) && (st.ph == PH_CMD) && (cmd_w[2:0] != REG_CONTROL)
      |=> st.sh[4:0] == 5'h00;
  endproperty
  a_limit_low_zero: assert property (p_limit_low_zero)
    else $error("limit read shows nonzero low bits");

  c_read_frame:  cover property ((st.ph == PH_RD) ##1 (st.ph == PH_DONE));
  c_write_frame: cover property (wr_go);
  c_alarm_on:    cover property ($rose(st.alarm));
  c_oneshot:     cover property (st.sleep && oneshot_req && (st.cv == CV_IDLE));

endmodule

// ==== sim/tac_host.sv ====
`timescale 1ns/1ps
// ==========================================================
// host side of the three-wire link
// ==========================================================
module tac_host (
  input  wire logic          mclk_in,  // block clock paces the link
  input  wire logic          sio_in,   // resolved data wire
  output tac_pkg::tac_link_t link_out  // pins toward the device
);
  import tac_pkg::*;
  // sck idle low, still between frames
  initial link_out = '{cs_n: 1'b1, sck: 1'b0, sio: 1'b0};
  // one frame: command byte then one word, msb first
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    rd = 16'h0000;
    link_out.cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // released line toggles so a stale bit never passes
      link_out.sio = (cmd[7] && i < 16) ? !link_out.sio : sh[i];
      repeat (4) @(negedge mclk_in);
      link_out.sck = 1'b1;
      // sample once settled, before oe can drop
      repeat (2) @(negedge mclk_in);
      if (i < 16) rd[i] = sio_in;
      repeat (2) @(negedge mclk_in);
      link_out.sck = 1'b0;
    end
    repeat (4) @(negedge mclk_in);
    link_out.cs_n = 1'b1;
    link_out.sio  = !link_out.sio;
    repeat (8) @(negedge mclk_in);
  endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
// ==========================================================
// self-checking bench of the alarm block
// ==========================================================
module testbench;
  import tac_pkg::*;
  logic        mclk_in;       // 10 MHz clock
  logic        nrst_in;       // sync reset, low active
  logic [15:0] meas;          // converter sample
  logic [15:0] rd;            // last word read
  logic [15:0] res;           // stored result
  logic        sio_o;         // device data bit
  logic        sio_oe;        // device drives wire
  logic        pin;           // alarm pin
  logic        busy;          // conversion running
  logic        done;          // completion pulse
  tac_link_t   link_h;        // host pins
  tac_link_t   link_d;        // pins as the device sees them
  int          error_cnt;     // mismatches
  int          total_checks;  // comparisons
  int          cyc;           // hang guard
  int          done_cnt;      // completion pulses seen
  localparam int BASE = 20;   // bench conversion base length
  // wire level from both drivers
  assign link_d = '{cs_n: link_h.cs_n, sck: link_h.sck,
                    sio: sio_oe ? sio_o : link_h.sio};
  tac_control #(.CONV_BASE_CYCLES(BASE)) DUT (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .link_in(link_d), .link_sio_out(sio_o), .link_sio_oe_out(sio_oe),
    .measurement_in(meas), .result_out(res), .converting_out(busy),
    .conv_done_out(done), .temperature_alarm_output_out(pin));
  tac_host host (.mclk_in(mclk_in), .sio_in(link_d.sio), .link_out(link_h));
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = !mclk_in;
  end
  // a hang counts as a mismatch
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    // completion pulses, counted one edge late
    if (done === 1'b1) done_cnt <= done_cnt + 1;
    if (cyc == 30000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
    host.xfer(c, 16'h0000, rd);
    check($sformatf("register %h", c), rd & m, e);
  endtask
  task automatic pin_is(input logic e);
    check("alarm pin", {15'h0000, pin}, {15'h0000, e});
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // cold start: low flag, toggle, done, limits
  task automatic t_reset();
    rchk(8'h81, 16'hFFFF, 16'h1300);
    rchk(8'h82, 16'hFFFF, 16'h4880);
    rchk(8'h83, 16'hFFFF, 16'h4600);
    pin_is(1'b1);
  endtask
  // low five limit bits never stick
  task automatic t_limits();
    host.xfer(8'h02, 16'h101F, rd);
    rchk(8'h82, 16'hFFFF, 16'h1000);
    host.xfer(8'h03, 16'h0800, rd);
    rchk(8'h83, 16'hFFFF, 16'h0800);
  endtask
  // hot, then clear while still hot
  task automatic t_hot();
    meas = 16'h2000;
    host.xfer(8'h01, 16'h0040, rd);
    w(50);
    pin_is(1'b1);
    rchk(8'h81, 16'h0C00, 16'h0C00);
    host.xfer(8'h01, 16'h2040, rd);
    rchk(8'h81, 16'h2800, 16'h0800);
  endtask
  // cooling: high flag held until read
  task automatic t_cold();
    meas = 16'h0000;
    w(50);
    pin_is(1'b0);
    rchk(8'h81, 16'h0E00, 16'h0600);
    rchk(8'h81, 16'h0E00, 16'h0200);
  endtask
  // disable masks pin and status
  task automatic t_disable();
    meas = 16'h2000;
    host.xfer(8'h01, 16'h0080, rd);
    w(50);
    pin_is(1'b1);
    rchk(8'h81, 16'h0800, 16'h0000);
    host.xfer(8'h01, 16'h0000, rd);
    w(50);
    pin_is(1'b0);
  endtask
  // longest resolution: busy time grows eightfold
  task automatic t_res();
    int k;
    host.xfer(8'h01, 16'h0030, rd);
    rchk(8'h81, 16'h0030, 16'h0030);
    k = 0;
    while (busy !== 1'b0) w(1);
    while (busy !== 1'b1) w(1);
    while (busy === 1'b1) begin
      k++;
      w(1);
    end
    check("busy cycles", 16'(k), 16'(BASE * 8));
    // back to the shortest length so later sleep holds stay short
    host.xfer(8'h01, 16'h0000, rd);
  endtask
  // sleep, then one single conversion
  task automatic t_sleep();
    int n;
    host.xfer(8'h01, 16'h8006, rd); // bits 3 and 0 kept zero
    w(60);
    host.xfer(8'h81, 16'h0000, rd);
    n = done_cnt;
    w(60);
    rchk(8'h81, 16'hC10E, 16'h8006);
    check("sleep pulses", 16'(done_cnt - n), 16'h0000);
    check("sleep busy", {15'h0000, busy}, 16'h0000);
    n = done_cnt;
    meas = 16'h1234;
    host.xfer(8'h01, 16'hC006, rd);
    w(60); // result trusted only once done
    check("result", res, 16'h1234);
    check("single pulses", 16'(done_cnt - n), 16'h0001);
    rchk(8'h81, 16'h4100, 16'h0100);
    rchk(8'h85, 16'hFFFF, 16'h0000);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    done_cnt = 0;
    meas = 16'h0000;
    nrst_in = 1'b0;
    w(10);
    nrst_in = 1'b1;
    t_reset();
    t_limits();
    t_hot();
    t_cold();
    t_disable();
    t_res();
    t_sleep();
    final_report();
  end
endmodule
